// file: otfs_top.sv
`timescale 1ns/1ps
module otfs_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [otfs_pkg::OTFS_AW-1:0] i_addr,
	input wire logic [otfs_pkg::OTFS_DW-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [otfs_pkg::OTFS_DW-1:0] o_rd_data,
	input wire otfs_pkg::otfs_flags_t i_flags,
	input wire logic [otfs_pkg::OTFS_VOLT_W-1:0] i_dc_bus_volts,
	input wire logic [otfs_pkg::OTFS_FREQ_W-1:0] i_out_freq,
	input wire logic i_ext_io,
	output logic o_fan_stop_req,
	output logic o_relay,
	output logic o_aux,
	output logic o_irq
);
	import otfs_pkg::*;

	// Configuration registers and the interrupt status.
	logic [OTFS_SEL_W-1:0] relay_function_select;
	logic [OTFS_SEL_W-1:0] aux_output_function_select;
	logic [OTFS_MODE_W-1:0] trip_indication_mode;
	logic fan_fault_policy;
	logic [OTFS_FREQ_W-1:0] detect_freq_setting;
	logic [OTFS_FREQ_W-1:0] detect_band_setting;
	logic [OTFS_VOLT_W-1:0] supply_level_setting;
	logic [OTFS_IRQ_W-1:0] irq_status;
	logic [OTFS_IRQ_W-1:0] irq_enable;

	// Option strap, caught once after reset release.
	logic ext_io;
	logic ext_io_taken;

	// Frequency detection state: high once the output has reached the detect frequency.
	logic freq_reached;

	// Decoded register accesses.
	wire logic wr_relay;
	wire logic wr_aux;
	wire logic wr_mode;
	wire logic wr_fan;
	wire logic wr_freq;
	wire logic wr_band;
	wire logic wr_level;
	wire logic wr_clear;
	wire logic wr_enable;
	assign wr_relay = i_wr && (i_addr == OTFS_ADDR_RELAY_SEL);
	assign wr_aux = i_wr && (i_addr == OTFS_ADDR_AUX_SEL);
	assign wr_mode = i_wr && (i_addr == OTFS_ADDR_TRIP_MODE);
	assign wr_fan = i_wr && (i_addr == OTFS_ADDR_FAN_POLICY);
	assign wr_freq = i_wr && (i_addr == OTFS_ADDR_DET_FREQ);
	assign wr_band = i_wr && (i_addr == OTFS_ADDR_DET_BAND);
	assign wr_level = i_wr && (i_addr == OTFS_ADDR_SUPPLY_LEVEL);
	assign wr_clear = i_wr && (i_addr == OTFS_ADDR_IRQ_CLEAR);
	assign wr_enable = i_wr && (i_addr == OTFS_ADDR_IRQ_ENABLE);

	// Condition terms for each selection code.
	wire logic cond_ov;
	wire logic cond_uv;
	wire logic cond_lost;
	wire logic cond_run;
	wire logic cond_stop;
	wire logic cond_steady;
	wire logic cond_trip;
	wire logic cond_fan;
	wire logic cond_fdt5;
	wire logic [OTFS_FREQ_W-1:0] half_band;
	wire logic [OTFS_FREQ_W-1:0] low_edge;
	assign cond_ov = i_flags.ov_trip && (i_dc_bus_volts > OTFS_OV_LEVEL);
	assign cond_uv = i_flags.uv_trip && (i_dc_bus_volts < supply_level_setting);
	assign cond_lost = i_flags.comm_lost | i_flags.analog_in_5v_lost | i_flags.analog_in_10v_lost
		| (ext_io & i_flags.analog_in_current_lost);
	assign cond_run = i_flags.run_cmd & i_flags.output_active;
	assign cond_stop = ~i_flags.running;
	assign cond_steady = i_flags.running & ~i_flags.accel & ~i_flags.decel;
	assign cond_trip = (trip_indication_mode == OTFS_TRIP_NO_UV) ?
		(i_flags.trip_any & ~i_flags.uv_trip) : i_flags.trip_any;
	assign cond_fan = i_flags.fan_fault && (fan_fault_policy == OTFS_FAN_CONTINUE);
	assign cond_fdt5 = ~freq_reached;
	assign half_band = {1'b0, detect_band_setting[OTFS_FREQ_W-1:1]};
	assign low_edge = (detect_freq_setting > half_band) ? (detect_freq_setting - half_band) : '0;

	// Condition vector indexed by selection code; unlisted codes stay low.
	wire logic [OTFS_NUM_CODES-1:0] cond_vec;
	assign cond_vec[3:0] = 4'h0;
	assign cond_vec[OTFS_CODE_FDT5] = cond_fdt5;
	assign cond_vec[OTFS_CODE_OVERLOAD] = i_flags.motor_overload;
	assign cond_vec[OTFS_CODE_DRV_OVERLOAD] = i_flags.drive_overload;
	assign cond_vec[OTFS_CODE_STALL] = i_flags.stall;
	assign cond_vec[OTFS_CODE_OV_TRIP] = cond_ov;
	assign cond_vec[OTFS_CODE_UV_TRIP] = cond_uv;
	assign cond_vec[OTFS_CODE_OVERHEAT] = i_flags.heatsink_overheat;
	assign cond_vec[OTFS_CODE_LOST_CMD] = cond_lost;
	assign cond_vec[OTFS_CODE_RUN] = cond_run;
	assign cond_vec[OTFS_CODE_STOP] = cond_stop;
	assign cond_vec[OTFS_CODE_STEADY] = cond_steady;
	assign cond_vec[OTFS_CODE_SPEED_SEARCH] = i_flags.speed_search;
	assign cond_vec[OTFS_CODE_READY] = i_flags.ready;
	assign cond_vec[OTFS_CODE_TRIP] = cond_trip;
	assign cond_vec[OTFS_CODE_FAN_WARN] = cond_fan;
	assign cond_vec[OTFS_CODE_BRAKE] = i_flags.brake_set;

	// One selector per terminal, each with its own code.
	wire logic relay_rise;
	wire logic aux_rise;
	otfs_sel u_relay (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_code(relay_function_select),
		.i_cond(cond_vec),
		.o_out(o_relay),
		.o_rise(relay_rise)
	);
	otfs_sel u_aux (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_code(aux_output_function_select),
		.i_cond(cond_vec),
		.o_out(o_aux),
		.o_rise(aux_rise)
	);

	// Events: relay rise, output 2 rise, lost command, fan fault.
	logic lost_q;
	logic fan_q;
	wire logic [OTFS_IRQ_W-1:0] irq_events;
	wire logic [OTFS_IRQ_W-1:0] next_irq_status;
	assign irq_events = {i_flags.fan_fault & ~fan_q, cond_lost & ~lost_q, aux_rise, relay_rise};
	assign next_irq_status = irq_events
		| (irq_status & ~(wr_clear ? i_wr_data[OTFS_IRQ_W-1:0] : 4'h0));

	// Read data selection; unmapped and write-only addresses read zero.
	wire logic [OTFS_DW-1:0] live_word;
	wire logic [OTFS_DW-1:0] rd_word;
	assign live_word = {8'h00, ext_io, freq_reached, o_aux, o_relay, cond_vec};
	assign rd_word = (i_addr == OTFS_ADDR_RELAY_SEL) ? {27'h0, relay_function_select} :
		(i_addr == OTFS_ADDR_AUX_SEL) ? {27'h0, aux_output_function_select} :
		(i_addr == OTFS_ADDR_TRIP_MODE) ? {29'h0, trip_indication_mode} :
		(i_addr == OTFS_ADDR_FAN_POLICY) ? {31'h0, fan_fault_policy} :
		(i_addr == OTFS_ADDR_DET_FREQ) ? {16'h0, detect_freq_setting} :
		(i_addr == OTFS_ADDR_DET_BAND) ? {16'h0, detect_band_setting} :
		(i_addr == OTFS_ADDR_SUPPLY_LEVEL) ? {22'h0, supply_level_setting} :
		(i_addr == OTFS_ADDR_LIVE) ? live_word :
		(i_addr == OTFS_ADDR_IRQ_STATUS) ? {28'h0, irq_status} :
		(i_addr == OTFS_ADDR_IRQ_ENABLE) ? {28'h0, irq_enable} : 32'h0;

	// Selection and mode registers.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			relay_function_select <= OTFS_RST_SEL;
			aux_output_function_select <= OTFS_RST_SEL;
			trip_indication_mode <= OTFS_RST_TRIP_MODE;
			fan_fault_policy <= OTFS_RST_FAN_POLICY;
		end else begin
			if (wr_relay) begin
				relay_function_select <= i_wr_data[OTFS_SEL_W-1:0];
			end
			if (wr_aux) begin
				aux_output_function_select <= i_wr_data[OTFS_SEL_W-1:0];
			end
			if (wr_mode) begin
				trip_indication_mode <= i_wr_data[OTFS_MODE_W-1:0];
			end
			if (wr_fan) begin
				fan_fault_policy <= i_wr_data[0];
			end
		end
	end

	// Detection and supply level settings.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			detect_freq_setting <= OTFS_RST_DET_FREQ;
			detect_band_setting <= OTFS_RST_DET_BAND;
			supply_level_setting <= OTFS_RST_UV_LEVEL;
		end else begin
			if (wr_freq) begin
				detect_freq_setting <= i_wr_data[OTFS_FREQ_W-1:0];
			end
			if (wr_band) begin
				detect_band_setting <= i_wr_data[OTFS_FREQ_W-1:0];
			end
			if (wr_level) begin
				supply_level_setting <= i_wr_data[OTFS_VOLT_W-1:0];
			end
		end
	end

	// Hysteresis: reached at the detect frequency, released below it by half the band.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			freq_reached <= 1'b0;
		end else if (i_out_freq >= detect_freq_setting) begin
			freq_reached <= 1'b1;
		end else if (i_out_freq <= low_edge) begin
			freq_reached <= 1'b0;
		end
	end

	// Catches the extended I/O strap on the first edge after reset release.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_io <= 1'b0;
			ext_io_taken <= 1'b0;
		end else if (!ext_io_taken) begin
			ext_io <= i_ext_io;
			ext_io_taken <= 1'b1;
		end
	end

	// Sticky interrupt status; a new event wins over a clear in the same cycle.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= '0;
			irq_enable <= OTFS_RST_IRQ_EN;
			lost_q <= 1'b0;
			fan_q <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_enable) begin
				irq_enable <= i_wr_data[OTFS_IRQ_W-1:0];
			end
			lost_q <= cond_lost;
			fan_q <= i_flags.fan_fault;
			o_irq <= |(irq_status & irq_enable);
		end
	end

	// Fan fault stops the drive only under the stop policy.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fan_stop_req <= 1'b0;
		end else begin
			o_fan_stop_req <= i_flags.fan_fault && (fan_fault_policy != OTFS_FAN_CONTINUE);
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= i_rd ? rd_word : 32'h0;
		end
	end
endmodule

// file: otfs_pkg.sv
package otfs_pkg;

	// Register bus geometry.
	localparam int OTFS_AW = 8;
	localparam int OTFS_DW = 32;

	// Register byte offsets.
	localparam logic [7:0] OTFS_ADDR_RELAY_SEL = 8'h00;
	localparam logic [7:0] OTFS_ADDR_AUX_SEL = 8'h04;
	localparam logic [7:0] OTFS_ADDR_TRIP_MODE = 8'h08;
	localparam logic [7:0] OTFS_ADDR_FAN_POLICY = 8'h0c;
	localparam logic [7:0] OTFS_ADDR_DET_FREQ = 8'h10;
	localparam logic [7:0] OTFS_ADDR_DET_BAND = 8'h14;
	localparam logic [7:0] OTFS_ADDR_SUPPLY_LEVEL = 8'h18;
	localparam logic [7:0] OTFS_ADDR_LIVE = 8'h1c;
	localparam logic [7:0] OTFS_ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OTFS_ADDR_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] OTFS_ADDR_IRQ_ENABLE = 8'h28;

	// Field widths.
	localparam int OTFS_SEL_W = 5;
	localparam int OTFS_MODE_W = 3;
	localparam int OTFS_FREQ_W = 16;
	localparam int OTFS_VOLT_W = 10;
	localparam int OTFS_NUM_CODES = 20;
	localparam int OTFS_IRQ_W = 4;

	// Selection codes.
	localparam logic [4:0] OTFS_CODE_FDT5 = 5'h04;
	localparam logic [4:0] OTFS_CODE_OVERLOAD = 5'h05;
	localparam logic [4:0] OTFS_CODE_DRV_OVERLOAD = 5'h06;
	localparam logic [4:0] OTFS_CODE_STALL = 5'h07;
	localparam logic [4:0] OTFS_CODE_OV_TRIP = 5'h08;
	localparam logic [4:0] OTFS_CODE_UV_TRIP = 5'h09;
	localparam logic [4:0] OTFS_CODE_OVERHEAT = 5'h0a;
	localparam logic [4:0] OTFS_CODE_LOST_CMD = 5'h0b;
	localparam logic [4:0] OTFS_CODE_RUN = 5'h0c;
	localparam logic [4:0] OTFS_CODE_STOP = 5'h0d;
	localparam logic [4:0] OTFS_CODE_STEADY = 5'h0e;
	localparam logic [4:0] OTFS_CODE_SPEED_SEARCH = 5'h0f;
	localparam logic [4:0] OTFS_CODE_READY = 5'h10;
	localparam logic [4:0] OTFS_CODE_TRIP = 5'h11;
	localparam logic [4:0] OTFS_CODE_FAN_WARN = 5'h12;
	localparam logic [4:0] OTFS_CODE_BRAKE = 5'h13;

	// Mode values.
	localparam logic [2:0] OTFS_TRIP_NO_UV = 3'h2;
	localparam logic OTFS_FAN_CONTINUE = 1'b0;

	// Fixed level: overvoltage trip threshold in volts.
	localparam logic [9:0] OTFS_OV_LEVEL = 10'h19a;

	// Reset values.
	localparam logic [4:0] OTFS_RST_SEL = 5'h11;
	localparam logic [2:0] OTFS_RST_TRIP_MODE = 3'h0;
	localparam logic OTFS_RST_FAN_POLICY = 1'b1;
	localparam logic [15:0] OTFS_RST_DET_FREQ = 16'h0bb8;
	localparam logic [15:0] OTFS_RST_DET_BAND = 16'h03e8;
	localparam logic [9:0] OTFS_RST_UV_LEVEL = 10'h0aa;
	localparam logic [3:0] OTFS_RST_IRQ_EN = 4'h0;

	// Internal status flags arriving from the drive.
	typedef struct packed {
		logic ov_trip;
		logic uv_trip;
		logic heatsink_overheat;
		logic run_cmd;
		logic output_active;
		logic running;
		logic accel;
		logic decel;
		logic ready;
		logic trip_any;
		logic fan_fault;
		logic brake_set;
		logic comm_lost;
		logic analog_in_5v_lost;
		logic analog_in_10v_lost;
		logic analog_in_current_lost;
		logic motor_overload;
		logic drive_overload;
		logic stall;
		logic speed_search;
	} otfs_flags_t;

	// Picks the condition that a selection code names; unused codes give zero.
	function automatic logic otfs_pick(input logic [19:0] vec, input logic [4:0] code);
		logic r;
		r = 1'b0;
		if (code < 5'(OTFS_NUM_CODES)) begin
			r = vec[code];
		end
		return r;
	endfunction

endpackage

// file: otfs_sel.sv
`timescale 1ns/1ps
module otfs_sel (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [otfs_pkg::OTFS_SEL_W-1:0] i_code,
	input wire logic [otfs_pkg::OTFS_NUM_CODES-1:0] i_cond,
	output logic o_out,
	output logic o_rise
);
	import otfs_pkg::*;

	wire logic next_out;

	// The selected condition drives the terminal.
	assign next_out = otfs_pick(i_cond, i_code);

	// Registered terminal level and a one-cycle pulse on its rising edge.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out <= 1'b0;
			o_rise <= 1'b0;
		end else begin
			o_out <= next_out;
			o_rise <= next_out & ~o_out;
		end
	end
endmodule

// file: otfs_load.sv
`timescale 1ns/1ps
// Stands in for the equipment wired to the relay and output 2 terminals.
module otfs_load (
	input wire logic i_clk,
	input wire logic i_relay,
	input wire logic i_aux,
	output logic o_relay_seen,
	output logic o_aux_seen,
	output int o_closures
);
	logic prev = 1'b0;
	// The coil and the input follow the terminal levels directly.
	assign o_relay_seen = i_relay;
	assign o_aux_seen = i_aux;
	// Counts relay pull-ins so that a single trip shows as a single closure.
	initial o_closures = 0;
	always @(posedge i_clk) begin
		prev <= i_relay;
		if (i_relay && !prev) begin
			o_closures <= o_closures + 1;
		end
	end
endmodule

// file: otfs_checker.sv
`timescale 1ns/1ps
module otfs_checker
	import otfs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [OTFS_AW-1:0] i_addr,
	input wire logic [OTFS_DW-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [OTFS_DW-1:0] o_rd_data,
	input wire otfs_flags_t i_flags,
	input wire logic [OTFS_VOLT_W-1:0] i_dc_bus_volts,
	input wire logic [OTFS_FREQ_W-1:0] i_out_freq,
	input wire logic i_ext_io,
	input wire logic o_fan_stop_req,
	input wire logic o_relay,
	input wire logic o_aux,
	input wire logic o_irq
);
	logic [4:0] rsel;
	logic [4:0] asel;
	logic [2:0] tmode;
	logic fpol;
	logic [2:0] wr_age;
	otfs_flags_t fl1;
	otfs_flags_t fl2;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Shadows of the settings, the age of the last write and the recent flag history.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsel <= OTFS_RST_SEL;
			asel <= OTFS_RST_SEL;
			tmode <= OTFS_RST_TRIP_MODE;
			fpol <= OTFS_RST_FAN_POLICY;
			wr_age <= 3'h0;
			fl1 <= '0;
			fl2 <= '0;
		end else begin
			if (i_wr && i_addr == OTFS_ADDR_RELAY_SEL) rsel <= i_wr_data[4:0];
			if (i_wr && i_addr == OTFS_ADDR_AUX_SEL) asel <= i_wr_data[4:0];
			if (i_wr && i_addr == OTFS_ADDR_TRIP_MODE) tmode <= i_wr_data[2:0];
			if (i_wr && i_addr == OTFS_ADDR_FAN_POLICY) fpol <= i_wr_data[0];
			wr_age <= i_wr ? 3'h0 : (wr_age == 3'h7 ? 3'h7 : wr_age + 3'h1);
			fl1 <= i_flags;
			fl2 <= fl1;
		end
	end
	// Settings untouched for a while and flags steady over the output latency.
	sequence s_settled;
		(wr_age > 3'h3) && (fl1 == fl2);
	endsequence
	chk_rd_quiet: assert property (!$past(i_rd) |-> o_rd_data == '0)
		else $error("read data not zero outside read cycle");
	chk_rd_relay: assert property (i_rd && i_addr == OTFS_ADDR_RELAY_SEL |=> o_rd_data == 32'(rsel))
		else $error("relay selection readback wrong");
	chk_unused_code: assert property (s_settled ##0 (rsel < 5'h04 || rsel > 5'h13) |-> !o_relay)
		else $error("relay driven on an unused code");
	chk_run_relay: assert property (s_settled ##0 rsel == OTFS_CODE_RUN |-> o_relay == (fl1.run_cmd && fl1.output_active))
		else $error("relay run indication wrong");
	chk_stop_aux: assert property (s_settled ##0 asel == OTFS_CODE_STOP |-> o_aux == !fl1.running)
		else $error("output 2 stop indication wrong");
	chk_steady_aux: assert property (s_settled ##0 asel == OTFS_CODE_STEADY |-> o_aux == (fl1.running && !fl1.accel && !fl1.decel))
		else $error("output 2 steady indication wrong");
	chk_trip_no_uv: assert property (s_settled ##0 (rsel == OTFS_CODE_TRIP && tmode == 3'h2) |-> o_relay == (fl1.trip_any && !fl1.uv_trip))
		else $error("relay trip indication wrong");
	chk_fan_warn: assert property (s_settled ##0 asel == OTFS_CODE_FAN_WARN |-> o_aux == (fl1.fan_fault && !fpol))
		else $error("fan warning wrong");
	chk_brake_relay: assert property (s_settled ##0 rsel == OTFS_CODE_BRAKE |-> o_relay == fl1.brake_set)
		else $error("brake indication wrong");
	chk_fan_stop: assert property (s_settled |-> o_fan_stop_req == (fl1.fan_fault && fpol))
		else $error("fan stop request wrong");
endmodule
bind otfs_top otfs_checker chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_flags(i_flags),
	.i_dc_bus_volts(i_dc_bus_volts), .i_out_freq(i_out_freq), .i_ext_io(i_ext_io),
	.o_fan_stop_req(o_fan_stop_req), .o_relay(o_relay), .o_aux(o_aux), .o_irq(o_irq));

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
	import otfs_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	otfs_flags_t i_flags = '0;
	logic [9:0] i_dc_bus_volts = 10'h0;
	logic [15:0] i_out_freq = 16'h0;
	logic i_ext_io = 1'b1;
	logic [31:0] o_rd_data;
	logic o_fan_stop_req, o_relay, o_aux, o_irq, relay_seen, aux_seen;
	int closures;
	int miscompares = 0;
	int samples_checked = 0;
	logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h28, 8'h24, 8'h40};
	logic [31:0] rv[10] = '{32'h11, 32'h11, 32'h0, 32'h1, 32'h0bb8, 32'h03e8, 32'h0aa, 32'h0, 32'h0, 32'h0};
	always #20 i_clk = ~i_clk;
	otfs_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_flags(i_flags),
		.i_dc_bus_volts(i_dc_bus_volts), .i_out_freq(i_out_freq), .i_ext_io(i_ext_io),
		.o_fan_stop_req(o_fan_stop_req), .o_relay(o_relay), .o_aux(o_aux), .o_irq(o_irq));
	otfs_load load (.i_clk(i_clk), .i_relay(o_relay), .i_aux(o_aux), .o_relay_seen(relay_seen),
		.o_aux_seen(aux_seen), .o_closures(closures));
	// Counts a comparison and reports a difference at once.
	task check(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// One-cycle register write and read on the plain port.
	task wr(input logic [7:0] a, input int d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= 32'(d);
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		`CHK("read data", e, o_rd_data);
	endtask
	// Reference model of a terminal for a given selection code.
	function automatic bit model_out(int c, otfs_flags_t f, int v, int tm, int fp, int uv, bit ext);
		case (c)
			5: return f.motor_overload;
			6: return f.drive_overload;
			7: return f.stall;
			8: return f.ov_trip && v > 410;
			9: return f.uv_trip && v < uv;
			10: return f.heatsink_overheat;
			11: return f.comm_lost || f.analog_in_5v_lost || f.analog_in_10v_lost || (ext && f.analog_in_current_lost);
			12: return f.run_cmd && f.output_active;
			13: return !f.running;
			14: return f.running && !f.accel && !f.decel;
			15: return f.speed_search;
			16: return f.ready;
			17: return tm == 2 ? f.trip_any && !f.uv_trip : f.trip_any;
			18: return f.fan_fault && fp == 0;
			19: return f.brake_set;
			default: return 1'b0;
		endcase
	endfunction
	// Reset, register defaults, interrupt handling, then random selections and flags.
	task automatic phase(input bit ext);
		int rs, as, tm, fp, uv, v, c0;
		otfs_flags_t f;
		i_rst_n <= 1'b0;
		i_ext_io <= ext;
		i_flags <= '0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rd_chk(ra[i], rv[i]);
		end
		wr(OTFS_ADDR_IRQ_CLEAR, 'hf);
		wr(OTFS_ADDR_IRQ_ENABLE, 1);
		wr(OTFS_ADDR_RELAY_SEL, 19);
		c0 = closures;
		i_flags.brake_set <= 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		`CHK("irq raised", 1, o_irq);
		`CHK("closures", c0 + 1, closures);
		rd_chk(OTFS_ADDR_IRQ_STATUS, 32'h1);
		wr(OTFS_ADDR_IRQ_ENABLE, 0);
		repeat (2) @(posedge i_clk);
		#1;
		`CHK("irq masked", 0, o_irq);
		wr(OTFS_ADDR_IRQ_ENABLE, 1);
		wr(OTFS_ADDR_IRQ_CLEAR, 1);
		repeat (2) @(posedge i_clk);
		#1;
		`CHK("irq cleared", 0, o_irq);
		// Code 4 walks the detection hysteresis: reach at the detect frequency, release half a band below.
		wr(OTFS_ADDR_RELAY_SEL, 4);
		@(posedge i_clk);
		i_out_freq <= 16'h0000;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK("fdt5 below", 1, o_relay);
		@(posedge i_clk);
		i_out_freq <= OTFS_RST_DET_FREQ;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK("fdt5 reached", 0, o_relay);
		@(posedge i_clk);
		i_out_freq <= 16'(OTFS_RST_DET_FREQ - (OTFS_RST_DET_BAND >> 1) + 16'h0001);
		repeat (3) @(posedge i_clk);
		#1;
		`CHK("fdt5 held", 0, o_relay);
		@(posedge i_clk);
		i_out_freq <= 16'(OTFS_RST_DET_FREQ - (OTFS_RST_DET_BAND >> 1));
		repeat (3) @(posedge i_clk);
		#1;
		`CHK("fdt5 released", 1, o_relay);
		repeat (50) begin
			rs = $urandom_range(31);
			as = $urandom_range(31);
			if (rs == 4) rs = 17;
			if (as == 4) as = 18;
			tm = $urandom_range(3);
			fp = $urandom_range(1);
			uv = $urandom_range(250, 100);
			wr(OTFS_ADDR_RELAY_SEL, rs);
			wr(OTFS_ADDR_AUX_SEL, as);
			wr(OTFS_ADDR_TRIP_MODE, tm);
			wr(OTFS_ADDR_FAN_POLICY, fp);
			wr(OTFS_ADDR_SUPPLY_LEVEL, uv);
			f = otfs_flags_t'(20'($urandom));
			v = $urandom_range(1) ? $urandom_range(415, 405) : uv - 3 + $urandom_range(6);
			@(posedge i_clk);
			i_flags <= f;
			i_dc_bus_volts <= 10'(v);
			repeat (3) @(posedge i_clk);
			#1;
			`CHK("relay", model_out(rs, f, v, tm, fp, uv, ext), relay_seen);
			`CHK("output 2", model_out(as, f, v, tm, fp, uv, ext), aux_seen);
			`CHK("fan stop", f.fan_fault && fp == 1, o_fan_stop_req);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence: extended variant first, then the plain one after a second reset.
	initial begin
		void'($urandom(32'hebd4));
		phase(1'b1);
		phase(1'b0);
		conclude();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#1000000;
		miscompares++;
		conclude();
	end
endmodule
